// ==== rtl/ddc_pkg.sv ====
// shared constants for the mixer/oscillator block and its controller
package ddc_pkg;
  localparam int DATA_W   = 18;
  localparam int TRIG_W   = 20;
  localparam int OUT_W    = 20;
  localparam int FREQ_W   = 32;
  localparam int PHASE_W  = 16;
  localparam int DITH_W   = 5;
  localparam int LUT_W    = 6;
  localparam int NPORT    = 4;
  localparam int NSYNC    = 8;
  localparam int CADDR_W  = 5;
  localparam int CDATA_W  = 16;
  localparam int BLK_W    = 3;
  // block register offsets, 16-bit words
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_ROUTE   = 5'h01;
  localparam logic [4:0] REG_SSEL    = 5'h02;
  localparam logic [4:0] REG_FA_LO   = 5'h03;
  localparam logic [4:0] REG_FA_HI   = 5'h04;
  localparam logic [4:0] REG_FB_LO   = 5'h05;
  localparam logic [4:0] REG_FB_HI   = 5'h06;
  localparam logic [4:0] REG_PH_A    = 5'h07;
  localparam logic [4:0] REG_PH_B    = 5'h08;
  localparam logic [4:0] REG_STATUS  = 5'h09;
  // control word fields
  localparam int CTL_ENA     = 0;
  localparam int CTL_DUAL    = 1;
  localparam int CTL_REMIX   = 2;
  localparam int CTL_ZEROQ   = 3;
  localparam int CTL_GAIN    = 4;
  localparam int CTL_DITH    = 5;
  localparam int CTL_MASK_LO = 6;
  localparam int CTL_RATE_LO = 8;
  localparam int SSEL_NCO    = 0;
  localparam int SSEL_DITH   = 3;
  localparam int SSEL_FREQ   = 6;
  localparam int SSEL_PHASE  = 9;
  localparam logic [4:0] DITH_SEED = 5'h1F;
  localparam int DITH_POS    = 21;
  localparam int MIX_SHIFT   = 19;
  // controller avalon word offsets (byte address = 4 * index)
  localparam logic [3:0] AV_CMD    = 4'h0;
  localparam logic [3:0] AV_CTRL   = 4'h1;
  localparam logic [3:0] AV_RDATA  = 4'h2;
  localparam logic [3:0] AV_OUTA   = 4'h3;
  localparam logic [3:0] AV_PORT0  = 4'h4;
  localparam int CMD_ADDR_LO = 16;
  localparam int CMD_BLK_LO  = 21;
  localparam int CMD_READ    = 24;
  localparam int AVC_GLOBAL  = 0;
  localparam int AVC_SYNC_LO = 8;
endpackage : ddc_pkg

// ==== rtl/ddc_link_if.sv ====
// link between the downconverter block and its controller
`timescale 1ns/100ps
`default_nettype none
interface ddc_link_if;
  import ddc_pkg::*;
  logic                          cfg_we;
  logic                          cfg_re;
  logic                          cfg_global;
  logic [BLK_W-1:0]              cfg_block;
  logic [CADDR_W-1:0]            cfg_addr;
  logic [CDATA_W-1:0]            cfg_wdata;
  logic [CDATA_W-1:0]            cfg_rdata;
  logic                          cfg_rvalid;
  logic [NPORT-1:0][DATA_W-1:0]  rx_data;
  logic [NSYNC-1:0]              sync_src;
  logic                          out_a_valid;
  logic                          out_b_valid;
  logic [OUT_W-1:0]              out_a_i;
  logic [OUT_W-1:0]              out_a_q;
  logic [OUT_W-1:0]              out_b_i;
  logic [OUT_W-1:0]              out_b_q;
  modport dev (
    input  cfg_we, cfg_re, cfg_global, cfg_block, cfg_addr, cfg_wdata,
    input  rx_data, sync_src,
    output cfg_rdata, cfg_rvalid, out_a_valid, out_b_valid,
    output out_a_i, out_a_q, out_b_i, out_b_q
  );
  modport ctl (
    output cfg_we, cfg_re, cfg_global, cfg_block, cfg_addr, cfg_wdata,
    output rx_data, sync_src,
    input  cfg_rdata, cfg_rvalid, out_a_valid, out_b_valid,
    input  out_a_i, out_a_q, out_b_i, out_b_q
  );
endinterface : ddc_link_if
`default_nettype wire

// ==== rtl/ddc_mixer_nco.sv ====
// downconverter front end: input routing, two oscillators, complex mixers
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - process only while enable bit set
// - dual bit selects two narrowband or one wideband
// - global write copies block 0/1 writes onward
// - complex mixer, 18-bit data, 20-bit sin/cos
// - dual mode gives two independently routed streams
// - host keeps input rate within mode limits
// - 4-bit routing field picks I and Q ports
// - host sets remix bit for full-rate real dual
// - zero-Q bit forces Q samples to zero
// - 2-bit rate field: clock divided 1,2,4,8
// - gain bit adds 6 dB at mixer output
// - accumulate frequency, add offset, index sin/cos table
// - 5-bit dither below phase bits when enabled
// - mask bits clear dither MSB and MSB-1
// - host loads frequency as two 16-bit writes
// - frequency word is signed two's complement
// - A word tunes wideband/A; B only in dual
// - 16-bit phase offsets span one full turn
// - new frequency/phase take effect on sync only
// - zero-phase sync clears accumulator; dither sync reseeds
// - A and B share one set of syncs
// - four 3-bit fields select sync sources
module ddc_mixer_nco
  import ddc_pkg::*;
#(
  parameter logic [BLK_W-1:0] BLOCK_ID = 3'h0
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  ddc_link_if.dev   link
);
  typedef logic signed [TRIG_W-1:0] trig_t;
  typedef logic [TRIG_W-1:0] lut_t [16];
  localparam lut_t SIN_LUT = '{
    20'h00000, 20'h0C8BD, 20'h18F8C, 20'h25281,
    20'h30FBC, 20'h3C56C, 20'h471CF, 20'h5133D,
    20'h5A828, 20'h62F20, 20'h6A6DB, 20'h70E2D,
    20'h7641C, 20'h7A7D1, 20'h7D8A5, 20'h7F623};

  function automatic trig_t sine(input logic [LUT_W-1:0] p);
    logic [3:0] idx;
    trig_t      mag;
    idx = p[4] ? ~p[3:0] : p[3:0];
    mag = trig_t'(SIN_LUT[idx]);
    sine = p[5] ? -mag : mag;
  endfunction : sine

  logic [15:0]        ctrl_q, ctrl_d, route_q, route_d, ssel_q, ssel_d;
  logic [FREQ_W-1:0]  fstage_q [2], fstage_d [2];
  logic [FREQ_W-1:0]  freq_q [2], freq_d [2];
  logic [PHASE_W-1:0] pstage_q [2], pstage_d [2];
  logic [PHASE_W-1:0] phase_q [2], phase_d [2];
  logic [FREQ_W-1:0]  acc_q [2], acc_d [2];
  logic [DITH_W-1:0]  dith_q, dith_d;
  logic [2:0]         div_q, div_d;
  logic [CDATA_W-1:0] rdata_q, rdata_d;
  logic               rvalid_q, rvalid_d;
  logic [1:0]         ovalid_q, ovalid_d;
  logic [OUT_W-1:0]   oi_q [2], oi_d [2], oq_q [2], oq_d [2];
  logic               sel_w, sel_r, tick, dual;
  logic               ev_nco, ev_dith, ev_freq, ev_phase;
  logic [2:0]         rate_mask;
  logic [DITH_W-1:0]  dith_eff;

  // own block, or broadcast copy from block 0/1 of same parity
  always_comb begin
    sel_r = link.cfg_block == BLOCK_ID;
    sel_w = sel_r || (link.cfg_global && link.cfg_block[2:1] == 2'b00 &&
                      link.cfg_block[0] == BLOCK_ID[0]);
  end

  always_comb begin
    dual      = ctrl_q[CTL_DUAL];
    // sample tick at clock divided by 1,2,4 or 8
    case (ctrl_q[CTL_RATE_LO +: 2])
      2'h0:    rate_mask = 3'h0;
      2'h1:    rate_mask = 3'h1;
      2'h2:    rate_mask = 3'h3;
      default: rate_mask = 3'h7;
    endcase
    tick      = ctrl_q[CTL_ENA] && ((div_q & rate_mask) == 3'h0);
    // one sync set, each event from a selected line
    ev_nco    = link.sync_src[ssel_q[SSEL_NCO +: 3]];
    ev_dith   = link.sync_src[ssel_q[SSEL_DITH +: 3]];
    ev_freq   = link.sync_src[ssel_q[SSEL_FREQ +: 3]];
    ev_phase  = link.sync_src[ssel_q[SSEL_PHASE +: 3]];
    // dither gated by enable, top two bits maskable
    dith_eff  = ctrl_q[CTL_DITH] ? dith_q : 5'h00;
    dith_eff[4] = dith_eff[4] & ~ctrl_q[CTL_MASK_LO + 1];
    dith_eff[3] = dith_eff[3] & ~ctrl_q[CTL_MASK_LO];
  end

  // register writes, reads and sync loading
  always_comb begin
    ctrl_d   = ctrl_q;
    route_d  = route_q;
    ssel_d   = ssel_q;
    fstage_d = fstage_q;
    pstage_d = pstage_q;
    freq_d   = freq_q;
    phase_d  = phase_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (link.cfg_we && sel_w) begin
      if (link.cfg_addr == REG_CTRL) begin
        ctrl_d = link.cfg_wdata;
      end else if (link.cfg_addr == REG_ROUTE) begin
        route_d = link.cfg_wdata;
      end else if (link.cfg_addr == REG_SSEL) begin
        ssel_d = link.cfg_wdata;
      end else if (link.cfg_addr == REG_FA_LO) begin
        fstage_d[0][15:0] = link.cfg_wdata;
      end else if (link.cfg_addr == REG_FA_HI) begin
        fstage_d[0][31:16] = link.cfg_wdata;
      end else if (link.cfg_addr == REG_FB_LO) begin
        fstage_d[1][15:0] = link.cfg_wdata;
      end else if (link.cfg_addr == REG_FB_HI) begin
        fstage_d[1][31:16] = link.cfg_wdata;
      end else if (link.cfg_addr == REG_PH_A) begin
        pstage_d[0] = link.cfg_wdata;
      end else if (link.cfg_addr == REG_PH_B) begin
        pstage_d[1] = link.cfg_wdata;
      end
    end
    // reads answered by the addressed block only
    if (link.cfg_re && sel_r) begin
      rvalid_d = 1'b1;
      if (link.cfg_addr == REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (link.cfg_addr == REG_ROUTE) begin
        rdata_d = route_q;
      end else if (link.cfg_addr == REG_SSEL) begin
        rdata_d = ssel_q;
      end else if (link.cfg_addr == REG_FA_LO) begin
        rdata_d = fstage_q[0][15:0];
      end else if (link.cfg_addr == REG_FA_HI) begin
        rdata_d = fstage_q[0][31:16];
      end else if (link.cfg_addr == REG_FB_LO) begin
        rdata_d = fstage_q[1][15:0];
      end else if (link.cfg_addr == REG_FB_HI) begin
        rdata_d = fstage_q[1][31:16];
      end else if (link.cfg_addr == REG_PH_A) begin
        rdata_d = pstage_q[0];
      end else if (link.cfg_addr == REG_PH_B) begin
        rdata_d = pstage_q[1];
      end else if (link.cfg_addr == REG_STATUS) begin
        rdata_d = {acc_q[0][31:18], dual, ctrl_q[CTL_ENA]};
      end else begin
        rdata_d = 16'h0000;
      end
    end
    // active words change only on their sync events
    if (ev_freq) begin
      freq_d = fstage_q;
    end
    if (ev_phase) begin
      phase_d = pstage_q;
    end
  end

  // oscillators and mixers, one per stream
  generate
    for (genvar s = 0; s < 2; s++) begin : g_str
      logic [FREQ_W-1:0]        arg;
      logic [3:0]               rsel;
      logic signed [DATA_W-1:0] xi, xq;
      trig_t                    sn, cs;
      logic signed [DATA_W+TRIG_W:0] pi, pq;
      always_comb begin
        // accumulator plus offset turn plus dither index table
        arg  = acc_q[s] + {phase_q[s], 16'h0000} +
               (FREQ_W'(dith_eff) << DITH_POS);
        sn   = sine(arg[31 -: LUT_W]);
        cs   = sine(arg[31 -: LUT_W] + 6'h10);
        // low two bits pick I port, high two bits Q port
        rsel = (s == 0) ? route_q[3:0] : route_q[7:4];
        xi   = link.rx_data[rsel[1:0]];
        xq   = link.rx_data[rsel[3:2]];
        // zero Q; remix-only real dual also drops Q
        if (ctrl_q[CTL_ZEROQ] || (dual && ctrl_q[CTL_REMIX])) begin
          xq = '0;
        end
        // (i + jq)(cos + j sin)
        pi   = (DATA_W+TRIG_W+1)'(xi * cs) - (DATA_W+TRIG_W+1)'(xq * sn);
        pq   = (DATA_W+TRIG_W+1)'(xi * sn) + (DATA_W+TRIG_W+1)'(xq * cs);
        acc_d[s] = acc_q[s];
        oi_d[s]  = oi_q[s];
        oq_d[s]  = oq_q[s];
        ovalid_d[s] = 1'b0;
        if (tick && (s == 0 || dual)) begin
          // signed word, wrap-around adds either direction
          acc_d[s] = acc_q[s] + freq_q[s];
          ovalid_d[s] = 1'b1;
          if (ctrl_q[CTL_GAIN]) begin
            oi_d[s] = pi[MIX_SHIFT-1 +: OUT_W];
            oq_d[s] = pq[MIX_SHIFT-1 +: OUT_W];
          end else begin
            oi_d[s] = pi[MIX_SHIFT +: OUT_W];
            oq_d[s] = pq[MIX_SHIFT +: OUT_W];
          end
        end
        if (ev_nco) begin
          acc_d[s] = '0;
        end
      end
    end
  endgenerate

  always_comb begin
    div_d  = div_q + 3'h1;
    dith_d = dith_q;
    if (tick) begin
      dith_d = {dith_q[3:0], dith_q[4] ^ dith_q[2]};
    end
    if (ev_dith) begin
      dith_d = DITH_SEED;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q   <= '0;
      route_q  <= '0;
      ssel_q   <= '0;
      fstage_q <= '{default: '0};
      pstage_q <= '{default: '0};
      freq_q   <= '{default: '0};
      phase_q  <= '{default: '0};
      acc_q    <= '{default: '0};
      oi_q     <= '{default: '0};
      oq_q     <= '{default: '0};
      ovalid_q <= '0;
      dith_q   <= DITH_SEED;
      div_q    <= '0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      route_q  <= route_d;
      ssel_q   <= ssel_d;
      fstage_q <= fstage_d;
      pstage_q <= pstage_d;
      freq_q   <= freq_d;
      phase_q  <= phase_d;
      acc_q    <= acc_d;
      oi_q     <= oi_d;
      oq_q     <= oq_d;
      ovalid_q <= ovalid_d;
      dith_q   <= dith_d;
      div_q    <= div_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign link.cfg_rdata   = rdata_q;
  assign link.cfg_rvalid  = rvalid_q;
  assign link.out_a_valid = ovalid_q[0];
  assign link.out_b_valid = ovalid_q[1];
  assign link.out_a_i     = oi_q[0];
  assign link.out_a_q     = oq_q[0];
  assign link.out_b_i     = oi_q[1];
  assign link.out_b_q     = oq_q[1];
endmodule : ddc_mixer_nco
`default_nettype wire

// ==== rtl/ddc_ctl.sv ====
// controller end: avalon slave driving block writes, samples and syncs
`timescale 1ns/100ps
`default_nettype none
module ddc_ctl
  import ddc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  ddc_link_if.ctl          link
);
  logic                         wait_q, wait_d;
  logic [31:0]                  rd_q, rd_d;
  logic                         we_q, we_d, re_q, re_d, glob_q, glob_d;
  logic [BLK_W-1:0]             blk_q, blk_d;
  logic [CADDR_W-1:0]           addr_q, addr_d;
  logic [CDATA_W-1:0]           wd_q, wd_d, cap_q, cap_d;
  logic                         capv_q, capv_d;
  logic [NSYNC-1:0]             sync_q, sync_d;
  logic [NPORT-1:0][DATA_W-1:0] port_q, port_d;
  logic [OUT_W-1:0]             outa_q, outa_d;
  logic                         take, commit;

  always_comb begin
    take   = (avs_read || avs_write) && wait_q;
    // writes land only at the edge where waitrequest is seen low
    commit = (avs_read || avs_write) && !wait_q;
    wait_d = !take;
    rd_d   = rd_q;
    we_d   = 1'b0;
    re_d   = 1'b0;
    sync_d = '0;
    glob_d = glob_q;
    blk_d  = blk_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    port_d = port_q;
    cap_d  = cap_q;
    capv_d = capv_q;
    outa_d = link.out_a_valid ? link.out_a_i : outa_q;
    if (link.cfg_rvalid) begin
      cap_d  = link.cfg_rdata;
      capv_d = 1'b1;
    end
    if (take && avs_read) begin
      if (avs_address == AV_CTRL) begin
        rd_d = {31'h0, glob_q};
      end else if (avs_address == AV_RDATA) begin
        rd_d = {15'h0, capv_q, cap_q};
      end else if (avs_address == AV_OUTA) begin
        rd_d = {12'h0, outa_q};
      end else if (avs_address >= AV_PORT0 && avs_address < 4'h8) begin
        rd_d = {14'h0, port_q[avs_address[1:0]]};
      end else begin
        rd_d = 32'h0;
      end
    end
    if (commit && avs_write) begin
      if (avs_address == AV_CMD) begin
        // each command carries one 16-bit word
        wd_d   = avs_writedata[15:0];
        addr_d = avs_writedata[CMD_ADDR_LO +: CADDR_W];
        blk_d  = avs_writedata[CMD_BLK_LO +: BLK_W];
        we_d   = !avs_writedata[CMD_READ];
        re_d   = avs_writedata[CMD_READ];
        capv_d = avs_writedata[CMD_READ] ? 1'b0 : capv_d;
      end else if (avs_address == AV_CTRL) begin
        glob_d = avs_writedata[AVC_GLOBAL];
        sync_d = avs_writedata[AVC_SYNC_LO +: NSYNC];
      end else if (avs_address >= AV_PORT0 && avs_address < 4'h8) begin
        port_d[avs_address[1:0]] = avs_writedata[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      rd_q   <= '0;
      we_q   <= 1'b0;
      re_q   <= 1'b0;
      glob_q <= 1'b0;
      blk_q  <= '0;
      addr_q <= '0;
      wd_q   <= '0;
      cap_q  <= '0;
      capv_q <= 1'b0;
      sync_q <= '0;
      port_q <= '0;
      outa_q <= '0;
    end else begin
      wait_q <= wait_d;
      rd_q   <= rd_d;
      we_q   <= we_d;
      re_q   <= re_d;
      glob_q <= glob_d;
      blk_q  <= blk_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      cap_q  <= cap_d;
      capv_q <= capv_d;
      sync_q <= sync_d;
      port_q <= port_d;
      outa_q <= outa_d;
    end
  end

  assign avs_readdata    = rd_q;
  assign avs_waitrequest = wait_q;
  assign link.cfg_we     = we_q;
  assign link.cfg_re     = re_q;
  assign link.cfg_global = glob_q;
  assign link.cfg_block  = blk_q;
  assign link.cfg_addr   = addr_q;
  assign link.cfg_wdata  = wd_q;
  assign link.sync_src   = sync_q;
  assign link.rx_data    = port_q;
endmodule : ddc_ctl
`default_nettype wire

// ==== verif/ddc_mixer_nco_chk.sv ====
// concurrent checks on the link between the block and its controller
`timescale 1ns/100ps
`default_nettype none
module ddc_mixer_nco_chk
  import ddc_pkg::*;
#(
  parameter logic [BLK_W-1:0] BLOCK_ID = 3'h0
) (
  input wire logic                         sys_clk,
  input wire logic                         resetn,
  input wire logic                         cfg_we,
  input wire logic                         cfg_re,
  input wire logic [BLK_W-1:0]             cfg_block,
  input wire logic [CADDR_W-1:0]           cfg_addr,
  input wire logic [CDATA_W-1:0]           cfg_wdata,
  input wire logic                         cfg_rvalid,
  input wire logic [NPORT-1:0][DATA_W-1:0] rx_data,
  input wire logic [NSYNC-1:0]             sync_src,
  input wire logic                         out_a_valid,
  input wire logic                         out_b_valid,
  input wire logic [OUT_W-1:0]             out_a_i,
  input wire logic [OUT_W-1:0]             out_a_q
);
  logic [CDATA_W-1:0] ctrl_q, ctrl_d;
  logic [7:0]         route_q, route_d;
  logic [DATA_W-1:0]  ia_q, ia_d;
  logic               r3_q, r3_d, zq_q, zq_d;
  // shadow of the block control and routing words
  always_comb begin
    ctrl_d  = ctrl_q;
    route_d = route_q;
    if (cfg_we && cfg_block == BLOCK_ID && cfg_addr == REG_CTRL) begin
      ctrl_d = cfg_wdata;
    end
    if (cfg_we && cfg_block == BLOCK_ID && cfg_addr == REG_ROUTE) begin
      route_d = cfg_wdata[7:0];
    end
    r3_d = ctrl_q[9:8] == 2'h3;
    zq_d = ctrl_q[CTL_ZEROQ];
    ia_d = rx_data[route_q[1:0]];
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= '0;
      route_q <= '0;
      ia_q    <= '0;
      r3_q    <= 1'b0;
      zq_q    <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      route_q <= route_d;
      ia_q    <= ia_d;
      r3_q    <= r3_d;
      zq_q    <= zq_d;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_read_answered: assert property (
    cfg_re && cfg_block == BLOCK_ID |=> cfg_rvalid)
    else $error("block read not answered");
  chk_no_stray_answer: assert property (
    cfg_rvalid |-> $past(cfg_re) && $past(cfg_block) == BLOCK_ID)
    else $error("read answer without own read");
  chk_off_silent: assert property (
    out_a_valid || out_b_valid |-> $past(ctrl_q[CTL_ENA]))
    else $error("sample while disabled");
  chk_b_wide_idle: assert property (
    out_b_valid |-> $past(ctrl_q[CTL_DUAL]))
    else $error("second stream active in wideband");
  chk_rate_eight: assert property (
    out_a_valid && r3_q |=> (!out_a_valid || !r3_q)[*7])
    else $error("samples closer than eight at rate eight");
  chk_rate_two: assert property (
    out_a_valid && $past(ctrl_q[9:8]) == 2'h1
    |=> !out_a_valid || $past(ctrl_q[9:8]) != 2'h1)
    else $error("samples closer than two at rate two");
  chk_zero_q: assert property (
    out_a_valid && zq_q && ia_q == '0 |-> out_a_i == '0 && out_a_q == '0)
    else $error("q not forced to zero");
  chk_hold_out: assert property (
    !out_a_valid |-> $stable(out_a_i) && $stable(out_a_q))
    else $error("output moved without valid");
  chk_cfg_pulse: assert property (
    cfg_we || cfg_re |=> !cfg_we && !cfg_re)
    else $error("config strobe longer than one cycle");
  chk_sync_pulse: assert property (
    sync_src != '0 |=> sync_src == '0)
    else $error("sync line held high");
endmodule : ddc_mixer_nco_chk
`default_nettype wire

// ==== verif/ddc_mixer_nco_bench.sv ====
// bench: controller and block joined, driven over avalon
`timescale 1ns/100ps
`default_nettype none
module ddc_mixer_nco_bench;
  import ddc_pkg::*;
  typedef struct packed {
    logic [15:0] v;
    logic [31:0] f;
    logic        acc;
  } note_t;
  logic        sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, r, fa, seed, a;
  logic [15:0] e;
  int          n_fail, total_checks, cyc, s_cyc, r_cyc, nb, k, i;
  note_t       notes[$];
  note_t       nt;
  ddc_link_if link ();
  ddc_mixer_nco #(.BLOCK_ID(3'h0)) ddc_mixer_nco_inst (
    .sys_clk(sys_clk), .resetn(resetn), .link(link));
  ddc_ctl ddc_ctl_inst (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  ddc_mixer_nco_chk #(.BLOCK_ID(3'h0)) ddc_mixer_nco_chk_inst (
    .sys_clk(sys_clk), .resetn(resetn), .cfg_we(link.cfg_we),
    .cfg_re(link.cfg_re), .cfg_block(link.cfg_block),
    .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata),
    .cfg_rvalid(link.cfg_rvalid), .rx_data(link.rx_data),
    .sync_src(link.sync_src), .out_a_valid(link.out_a_valid),
    .out_b_valid(link.out_b_valid), .out_a_i(link.out_a_i),
    .out_a_q(link.out_a_q));
  always #12.5 sys_clk = ~sys_clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task end_sim;
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task av(input logic wr, input logic [3:0] ad, input logic [31:0] d,
          output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    avs_address   <= ad;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      end_sim;
    end
  endtask : av
  task blk_wr(input logic [2:0] b, input logic [4:0] ad, input logic [15:0] d);
    av(1'b1, AV_CMD, {7'h0, 1'b0, b, ad, d}, q);
  endtask : blk_wr
  // note the expected answer, then poll until the controller holds it
  task blk_rd(input logic [2:0] b, input logic [4:0] ad, input logic [15:0] v,
              input logic [31:0] f, input logic ac);
    int n;
    av(1'b1, AV_CMD, {7'h0, 1'b1, b, ad, 16'h0000}, q);
    notes.push_back('{v, f, ac});
    n = 0;
    do begin
      av(1'b0, AV_RDATA, 32'h0, q);
      n++;
    end while (q[16] !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_sim;
    end
    if (!ac) check({16'h0, q[15:0]}, {16'h0, v});
  endtask : blk_rd
  // watcher: sync and read moments, answers against the oldest note
  always @(posedge sys_clk) begin
    cyc++;
    if (link.sync_src[2] === 1'b1) s_cyc = cyc;
    if (link.cfg_re === 1'b1) r_cyc = cyc;
    if (link.out_b_valid === 1'b1) nb++;
    if (link.cfg_rvalid === 1'b1) begin
      nt = notes.pop_front();
      e  = nt.v;
      a  = nt.f * 32'(r_cyc - s_cyc - 1);
      if (nt.acc) e = {a[31:18], 2'b01};
      check({16'h0, link.cfg_rdata}, {16'h0, e});
    end
  end
  initial begin
    sys_clk = 1'b0; resetn = 1'b0; avs_address = 4'h0; avs_read = 1'b0;
    avs_write = 1'b0; avs_writedata = 32'h0; seed = 32'h00014CE1;
    fa = 32'h0; cyc = 0; s_cyc = 0; r_cyc = 0; nb = 0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    av(1'b0, 4'hF, 32'h0, q);
    check(q, 32'h0);
    blk_rd(3'h0, REG_CTRL, 16'h0000, 32'h0, 1'b0);
    blk_rd(3'h0, REG_SSEL, 16'h0000, 32'h0, 1'b0);
    r = rnd();
    blk_wr(3'h0, REG_ROUTE, {8'h00, r[7:0]});
    blk_rd(3'h0, REG_ROUTE, {8'h00, r[7:0]}, 32'h0, 1'b0);
    av(1'b1, AV_CTRL, 32'h1, q);
    blk_wr(3'h1, REG_PH_A, 16'h1234);
    av(1'b1, AV_CTRL, 32'h0, q);
    blk_wr(3'h2, REG_PH_A, 16'h5678);
    blk_rd(3'h0, REG_PH_A, 16'h0000, 32'h0, 1'b0);
    blk_wr(3'h0, REG_SSEL, 16'h0492);
    blk_wr(3'h0, REG_CTRL, 16'h0031);
    for (k = 0; k < 4; k++) begin
      r = (k == 3) ? 32'hFFFC0000 : rnd();
      blk_wr(3'h0, REG_FA_LO, r[15:0]);
      blk_wr(3'h0, REG_FA_HI, r[31:16]);
      blk_wr(3'h0, REG_FB_LO, ~r[15:0]);
      blk_rd(3'h0, REG_FA_HI, r[31:16], 32'h0, 1'b0);
      blk_rd(3'h0, REG_STATUS, 16'h0, fa, 1'b1);
      av(1'b1, AV_CTRL, 32'h100, q);
      blk_rd(3'h0, REG_STATUS, 16'h0, fa, 1'b1);
      av(1'b1, AV_CTRL, 32'h400, q);
      fa = r;
      blk_rd(3'h0, REG_STATUS, 16'h0, fa, 1'b1);
    end
    blk_wr(3'h0, REG_CTRL, 16'h0000);
    av(1'b1, AV_CTRL, 32'h400, q);
    blk_rd(3'h0, REG_STATUS, 16'h0000, 32'h0, 1'b0);
    for (i = 0; i < 4; i++) begin
      r = (i == 0) ? 32'h0 : rnd();
      av(1'b1, AV_PORT0 + 4'(i), {14'h0, r[17:0]}, q);
    end
    blk_wr(3'h0, REG_ROUTE, 16'h00E4);
    blk_wr(3'h0, REG_CTRL, 16'h03FB);
    nb = 0;
    repeat (40) @(posedge sys_clk);
    check({31'h0, nb >= 4}, 32'h1);
    av(1'b0, AV_OUTA, 32'h0, q);
    check({12'h0, q[19:0]}, 32'h0);
    r = rnd();
    av(1'b1, AV_PORT0, {14'h0, r[17:0]}, q);
    blk_wr(3'h0, REG_CTRL, 16'h0017);
    nb = 0;
    repeat (30) @(posedge sys_clk);
    check({31'h0, nb >= 24}, 32'h1);
    blk_wr(3'h0, REG_CTRL, 16'h011B);
    repeat (30) @(posedge sys_clk);
    blk_rd(3'h0, REG_CTRL, 16'h011B, 32'h0, 1'b0);
    check(32'(notes.size()), 32'h0);
    end_sim;
  end
endmodule : ddc_mixer_nco_bench
`default_nettype wire
